// ---- pkg/ssif_pkg.sv ----
// Package: register map, function indices, modes and reset values for the sequence input block
package ssif_pkg;

  // ==========================================================
  // Function slots of the sequence input vector
  localparam int SSIF_NF = 21;
  localparam int F_PROP = 0;
  localparam int F_PAUSE = 1;
  localparam int F_CANCEL = 2;
  localparam int F_TEACH = 3;
  localparam int F_MSW = 4;
  localparam int F_POSC = 5;
  localparam int F_TRQC = 6;
  localparam int F_OVEN = 7;
  localparam int F_OV1 = 8;
  localparam int F_IEN = 12;
  localparam int F_DCLR = 13;
  localparam int F_X1 = 14;
  localparam int F_FWD = 17;
  localparam int F_REV = 18;
  localparam int F_RAT1 = 19;
  localparam int F_RAT2 = 20;
  // Map bit of the interrupt function, which only the fifth input feeds
  localparam int F_INTR = 21;
  localparam int SSIF_NMAP = 22;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] A_CFG = 8'h00;
  localparam logic [7:0] A_MAP = 8'h04;
  localparam logic [7:0] A_TRAVEL = 8'h08;
  localparam logic [7:0] A_OVW = 8'h0C;
  localparam logic [7:0] A_MAXSPD = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_SPD_BASE = 8'h20;
  localparam logic [7:0] A_SPD_LAST = 8'h38;
  localparam logic [7:0] A_TAB_BASE = 8'h40;
  localparam int CFG_CLRFORM_BIT = 4;

  // ==========================================================
  // Reset values
  localparam logic [4:0] CFG_RST = 5'h00;
  localparam logic [21:0] MAP_RST = 22'h000000;
  localparam logic [31:0] TRAVEL_RST = 32'h00000000;
  localparam logic [31:0] OVW_RST = 32'h5028140A;
  localparam logic [15:0] MAXSPD_RST = 16'hFFFF;
  localparam logic [15:0] SPD_RST = 16'h0000;

  // ==========================================================
  // Control mode parameter codes and override figures
  localparam logic [3:0] CM_SPD = 4'h1;
  localparam logic [3:0] CM_TRQ = 4'h2;
  localparam logic [3:0] CM_PS = 4'h3;
  localparam logic [3:0] CM_PT = 4'h4;
  localparam logic [3:0] CM_ST = 4'h5;
  localparam logic [3:0] CM_EXT = 4'h6;
  localparam logic [3:0] CM_POSN = 4'h7;
  localparam logic [9:0] OVR_LIM_PCT = 10'h096;
  localparam logic [9:0] PCT_UNIT = 10'h064;

  typedef enum logic [1:0] {SSIF_POS, SSIF_SPD, SSIF_TRQ} ssif_ctl_t;
  typedef enum logic [1:0] {SSIF_IP_IDLE, SSIF_IP_RUN} ssif_ip_t;

  // Active control loop from the mode code and the switching inputs
  function automatic ssif_ctl_t ssif_mode_dec(input logic [3:0] m, input logic sw,
                                              input logic posc, input logic trqc);
    ssif_ctl_t r;
    r = SSIF_POS;
    if (m == CM_SPD) r = SSIF_SPD;
    else if (m == CM_TRQ) r = SSIF_TRQ;
    else if (m == CM_PS) r = sw ? SSIF_SPD : SSIF_POS;
    else if (m == CM_PT) r = sw ? SSIF_TRQ : SSIF_POS;
    else if (m == CM_ST) r = sw ? SSIF_TRQ : SSIF_SPD;
    else if (m == CM_EXT) r = posc ? SSIF_POS : (trqc ? SSIF_TRQ : SSIF_SPD);
    return r;
  endfunction : ssif_mode_dec

endpackage : ssif_pkg

// ---- src/ssif_sync_edge.sv ----
// Two-stage synchroniser with rising-edge detect for the sequence inputs
module ssif_sync_edge import ssif_pkg::*; #(
  parameter int W = 26
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Raw levels in, clean levels and edges out
  input wire logic [W-1:0] raw_in,
  output logic [W-1:0] level_out,
  output logic [W-1:0] rise_out
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;

  // ==========================================================
  // Only sync_r reads meta_r; the edge compares the clean stages
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= raw_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level_out = sync_r;
  assign rise_out = sync_r & ~prev_r;

endmodule : ssif_sync_edge

// ---- src/ssif_speed_scale.sv ----
// Speed override scaling with the 150 percent and maximum speed limits
module ssif_speed_scale import ssif_pkg::*; (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Speed and override controls
  input wire logic [15:0] base_in,
  input wire logic [15:0] max_in,
  input wire logic [31:0] weights_in,
  input wire logic [3:0] ovr_bits_in,
  input wire logic ovr_en_in,
  // Registered speed reference
  output logic [15:0] speed_out
);

  logic [15:0] speed_r;
  logic [9:0] factor;
  logic [25:0] scaled;
  logic [25:0] cap;
  logic [15:0] lim;
  logic [15:0] ovr_spd;

  // ==========================================================
  // Factor is the sum of the weights of the active override bits
  assign factor = (ovr_bits_in[0] ? {2'b00, weights_in[7:0]} : 10'h000)
                + (ovr_bits_in[1] ? {2'b00, weights_in[15:8]} : 10'h000)
                + (ovr_bits_in[2] ? {2'b00, weights_in[23:16]} : 10'h000)
                + (ovr_bits_in[3] ? {2'b00, weights_in[31:24]} : 10'h000);
  // Operands widened to the full product width so no carry is lost before the divide
  assign scaled = ({10'h000, base_in} * {16'h0000, factor}) / {16'h0000, PCT_UNIT};
  assign cap = ({10'h000, base_in} * {16'h0000, OVR_LIM_PCT}) / {16'h0000, PCT_UNIT};
  // Ceiling is the smaller of 150 percent of the speed and the maximum
  assign lim = (cap > {10'h000, max_in}) ? max_in : cap[15:0];
  assign ovr_spd = (scaled > {10'h000, lim}) ? lim : scaled[15:0];

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) speed_r <= 16'h0000;
    else speed_r <= ovr_en_in ? ovr_spd : base_in;
  end

  assign speed_out = speed_r;

  a_ovr_ceiling: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    ovr_en_in |=> speed_r <= $past(max_in)) else $error("override above maximum");

endmodule : ssif_speed_scale

// ---- src/ssif_seq_inputs.sv ----
// Sequence input function decoder: APB registers, pause, cancel, teach, modes, override
//
// The register offsets and the APB interface to the registers are this design's own decisions.
module ssif_seq_inputs import ssif_pkg::*; #(
  parameter int NTAB = 16
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Sequence input terminals
  input wire logic [SSIF_NF-1:0] func_in,
  input wire logic fifth_general_input_in,
  input wire logic [3:0] table_addr_in,
  // Motion core status
  input wire logic [31:0] cmd_pos_in,
  input wire logic [31:0] fb_pos_in,
  input wire logic [15:0] analog_speed_in,
  input wire logic run_active_in,
  input wire logic pulse_op_in,
  input wire logic manual_op_in,
  // Decoded commands to the motion core
  output logic [1:0] ctl_mode_out,
  output logic prop_ctrl_out,
  output logic pause_out,
  output logic decel_cfg_out,
  output logic cancel_out,
  output logic pulse_op_en_out,
  output logic torque_en_out,
  output logic torque_rev_out,
  output logic int_stop_out,
  output logic [15:0] speed_ref_out,
  output logic cmd_load_out,
  output logic [31:0] cmd_load_val_out,
  output logic rotation_inhibit_out
);

  // ==========================================================
  // Configuration and state registers
  logic [4:0] cfg_r;
  logic [21:0] map_r;
  logic [31:0] travel_r;
  logic [31:0] ovw_r;
  logic [15:0] maxspd_r;
  logic [15:0] spd_tab [7];
  logic [31:0] pos_tab [NTAB];
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  ssif_ip_t ip_state_r;
  ssif_ip_t ip_state_nxt;
  logic [31:0] ip_start_r;
  logic [15:0] ip_speed_r;
  logic [1:0] ctl_mode_r;
  logic prop_r;
  logic pause_r;
  logic pause_nxt;
  logic decel_r;
  logic cancel_r;
  logic cancel_nxt;
  logic pulse_en_r;
  logic trq_en_r;
  logic trq_rev_r;
  logic int_stop_r;
  logic int_stop_nxt;
  logic load_r;
  logic [31:0] load_val_r;
  logic inhibit_r;

  // ==========================================================
  // Input conditioning
  logic [25:0] raw_all;
  logic [25:0] lvl_all;
  logic [25:0] rise_all;
  logic [SSIF_NMAP-1:0] lv;
  logic [SSIF_NMAP-1:0] re;
  logic [3:0] tab_addr;

  // The interrupt slot is fed from the fifth input alone
  assign raw_all = {table_addr_in, fifth_general_input_in, func_in};

  ssif_sync_edge #(.W(26)) u_sync (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .raw_in(raw_all),
    .level_out(lvl_all),
    .rise_out(rise_all)
  );

  // Unmapped functions read as off, so their edges never fire either
  assign lv = lvl_all[21:0] & map_r;
  assign re = rise_all[21:0] & map_r;
  assign tab_addr = lvl_all[25:22];

  // ==========================================================
  // Mode decode
  wire [3:0] cm = cfg_r[3:0];
  wire clr_level = cfg_r[CFG_CLRFORM_BIT];
  wire is_ext = (cm == CM_EXT);
  wire is_posn = (cm == CM_POSN);
  // Switch input only counts in the dual modes, inside the decode
  wire ssif_ctl_t mode_now = ssif_mode_dec(cm, lv[F_MSW], lv[F_POSC], lv[F_TRQC]);
  wire dclr_hold = lv[F_DCLR];
  wire run_cmd = (lv[F_FWD] | lv[F_REV]) & ~dclr_hold;
  // Pulse operation only after position control with a ratio input on
  wire pulse_en = is_ext & lv[F_POSC] & (lv[F_RAT1] | lv[F_RAT2]);
  wire ratio_op = pulse_op_in | pulse_en;

  // ==========================================================
  // Pause and cancel
  wire pause_ok = run_active_in & ~ratio_op & ~manual_op_in;
  // Engage on the edge, hold while the level stays, resume on release
  assign pause_nxt = lv[F_PAUSE] & (pause_r | (re[F_PAUSE] & pause_ok));
  // Cancel is a one-cycle abort request, blocked in pulse operation
  assign cancel_nxt = re[F_CANCEL] & run_active_in & ~ratio_op;

  // ==========================================================
  // Speed selection and interrupt positioning
  wire [2:0] sel_code = {lv[F_X1+2], lv[F_X1+1], lv[F_X1]};
  wire [15:0] sel_spd = (sel_code == 3'b000) ? analog_speed_in : spd_tab[sel_code - 3'd1];
  wire ip_run = (ip_state_r == SSIF_IP_RUN);
  wire [15:0] base_spd = ip_run ? ip_speed_r : sel_spd;
  wire ip_arm = (is_ext | is_posn) & lv[F_IEN] & re[F_INTR];
  wire [31:0] ip_delta = fb_pos_in - ip_start_r;
  wire [31:0] ip_dist = ip_delta[31] ? (32'h00000000 - ip_delta) : ip_delta;
  wire ip_reached = ip_run & (ip_dist >= travel_r);
  // Override stays on during interrupt runs, off in torque and pulse paths
  wire ovr_en = lv[F_OVEN] & (mode_now != SSIF_TRQ) & ~ratio_op;
  assign int_stop_nxt = ip_reached & ~cancel_nxt;

  always_comb begin
    ip_state_nxt = ip_state_r;
    unique case (ip_state_r)
      SSIF_IP_IDLE: if (ip_arm) ip_state_nxt = SSIF_IP_RUN;
      SSIF_IP_RUN: if (ip_reached || cancel_nxt) ip_state_nxt = SSIF_IP_IDLE;
    endcase
  end

  ssif_speed_scale u_scale (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .base_in(base_spd),
    .max_in(maxspd_r),
    .weights_in(ovw_r),
    .ovr_bits_in(lv[F_OV1+3:F_OV1]),
    .ovr_en_in(ovr_en),
    .speed_out(speed_ref_out)
  );

  // ==========================================================
  // Teach and deviation clear
  // Teach has no forced-stop or servo-on terms by intent
  wire teach_we = re[F_TEACH] & is_posn;
  // Clear form picks rising edge or level action
  wire clr_fire = clr_level ? dclr_hold : re[F_DCLR];

  // ==========================================================
  // APB decode
  wire wr_en = psel_in & penable_in & pwrite_in & pready_r;
  wire setup = psel_in & ~penable_in;
  wire in_spd = (paddr_in >= A_SPD_BASE) && (paddr_in <= A_SPD_LAST);
  wire in_tab = (paddr_in >= A_TAB_BASE) && (paddr_in < A_TAB_BASE + 8'(4 * NTAB));
  wire [7:0] spd_off = paddr_in - A_SPD_BASE;
  wire [7:0] tab_off = paddr_in - A_TAB_BASE;
  wire [2:0] spd_idx = spd_off[4:2];
  wire [3:0] tab_idx = tab_off[5:2];
  wire aligned = (paddr_in[1:0] == 2'b00);
  wire [31:0] status_w = {24'h000000, int_stop_r, inhibit_r, pause_r,
                          ip_run, 2'b00, ctl_mode_r};
  wire addr_ok = aligned & ((paddr_in == A_CFG) | (paddr_in == A_MAP) |
                            (paddr_in == A_TRAVEL) | (paddr_in == A_OVW) |
                            (paddr_in == A_MAXSPD) | (paddr_in == A_STATUS) |
                            in_spd | in_tab);
  // Status and table are read-only; writes there are refused
  wire ro_hit = (paddr_in == A_STATUS) | in_tab;
  wire [31:0] rd_w = (paddr_in == A_CFG) ? {27'h0000000, cfg_r} :
                     (paddr_in == A_MAP) ? {10'h000, map_r} :
                     (paddr_in == A_TRAVEL) ? travel_r :
                     (paddr_in == A_OVW) ? ovw_r :
                     (paddr_in == A_MAXSPD) ? {16'h0000, maxspd_r} :
                     (paddr_in == A_STATUS) ? status_w :
                     in_spd ? {16'h0000, spd_tab[spd_idx]} :
                     in_tab ? pos_tab[tab_idx] : 32'h00000000;
  wire bad_acc = ~addr_ok | (pwrite_in & ro_hit);

  // Zero-wait slave: ready rises in the first access cycle
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup & bad_acc;
      prdata_r <= (setup & ~pwrite_in & ~bad_acc) ? rd_w : 32'h00000000;
    end
  end

  // Software-owned configuration registers
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cfg_r <= CFG_RST;
      map_r <= MAP_RST;
      travel_r <= TRAVEL_RST;
      ovw_r <= OVW_RST;
      maxspd_r <= MAXSPD_RST;
    end else if (wr_en & ~pslverr_r) begin
      if (paddr_in == A_CFG) cfg_r <= pwdata_in[4:0];
      if (paddr_in == A_MAP) map_r <= pwdata_in[21:0];
      if (paddr_in == A_TRAVEL) travel_r <= pwdata_in;
      if (paddr_in == A_OVW) ovw_r <= pwdata_in;
      if (paddr_in == A_MAXSPD) maxspd_r <= pwdata_in[15:0];
    end
  end

  // Stored speeds 1 to 7
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < 7; i++) spd_tab[i] <= SPD_RST;
    end else if (wr_en & ~pslverr_r & in_spd) begin
      spd_tab[spd_idx] <= pwdata_in[15:0];
    end
  end

  // Teach table: no reset, it holds positions, not control state
  always_ff @(posedge sys_clk_in) begin
    if (teach_we) pos_tab[tab_addr] <= cmd_pos_in;
  end

  // ==========================================================
  // Motion command registers
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ip_state_r <= SSIF_IP_IDLE;
      ip_start_r <= 32'h00000000;
      ip_speed_r <= 16'h0000;
    end else begin
      ip_state_r <= ip_state_nxt;
      if (ip_arm & ~ip_run) begin
        ip_start_r <= fb_pos_in;
        ip_speed_r <= sel_spd;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctl_mode_r <= 2'b00;
      prop_r <= 1'b0;
      pause_r <= 1'b0;
      decel_r <= 1'b0;
      cancel_r <= 1'b0;
      pulse_en_r <= 1'b0;
      trq_en_r <= 1'b0;
      trq_rev_r <= 1'b0;
      int_stop_r <= 1'b0;
      load_r <= 1'b0;
      load_val_r <= 32'h00000000;
      inhibit_r <= 1'b0;
    end else begin
      ctl_mode_r <= mode_now;
      prop_r <= lv[F_PROP];
      pause_r <= pause_nxt;
      decel_r <= pause_nxt | cancel_nxt;
      cancel_r <= cancel_nxt;
      pulse_en_r <= pulse_en & ~dclr_hold;
      trq_en_r <= is_ext & lv[F_TRQC] & run_cmd;
      trq_rev_r <= lv[F_REV] & ~lv[F_FWD];
      int_stop_r <= int_stop_nxt;
      load_r <= clr_fire;
      load_val_r <= fb_pos_in;
      inhibit_r <= dclr_hold;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata_out = prdata_r;
  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  assign ctl_mode_out = ctl_mode_r;
  assign prop_ctrl_out = prop_r;
  assign pause_out = pause_r;
  assign decel_cfg_out = decel_r;
  assign cancel_out = cancel_r;
  assign pulse_op_en_out = pulse_en_r;
  assign torque_en_out = trq_en_r;
  assign torque_rev_out = trq_rev_r;
  assign int_stop_out = int_stop_r;
  assign cmd_load_out = load_r;
  assign cmd_load_val_out = load_val_r;
  assign rotation_inhibit_out = inhibit_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  a_unmapped_off: assert property (!map_r[F_PAUSE] && !pause_r |=> !pause_r)
    else $error("unmapped pause took effect");
  a_pause_edge: assert property (re[F_PAUSE] && pause_ok |=> pause_r && decel_r)
    else $error("pause edge not taken");
  a_pause_ignored: assert property (!pause_r && (manual_op_in || ratio_op) |=> !pause_r)
    else $error("pause taken in jog or pulse operation");
  a_cancel_pulse: assert property (cancel_r |-> $past(run_active_in) ##1 !cancel_r)
    else $error("cancel not a single pulse");
  a_teach_mode: assert property (teach_we |-> cfg_r[3:0] == CM_POSN)
    else $error("teach outside positioning mode");
  a_mode_fixed: assert property (cm == CM_POSN |=> ctl_mode_r == SSIF_POS)
    else $error("mode switch honoured outside dual modes");
  a_torque_run: assert property (trq_en_r |-> $past(lv[F_FWD] || lv[F_REV]))
    else $error("torque without run command");
  a_int_stop: assert property (ip_reached && !cancel_nxt |=> int_stop_r ##1 !ip_run)
    else $error("interrupt travel stop missing");
  a_clear_load: assert property (load_r |-> load_val_r == $past(fb_pos_in))
    else $error("clear loaded wrong position");
  a_clear_block: assert property (dclr_hold |=> inhibit_r && !trq_en_r)
    else $error("rotation not blocked during clear");

  c_pause_resume: cover property (pause_r ##[1:20] !pause_r);
  c_int_done: cover property (ip_run ##[1:50] int_stop_r);
  c_teach_write: cover property (teach_we);
  c_clear_level: cover property ((clr_level && load_r) [*3]);

endmodule : ssif_seq_inputs

// ---- bench/ssif_host_model.sv ----
// Host controller model that drives the sequence input terminals
module ssif_host_model import ssif_pkg::*; (
  // Clock
  input wire logic sys_clk_in,
  // Terminal levels
  output logic [SSIF_NF-1:0] func_out,
  output logic fifth_general_input_out,
  output logic [3:0] table_addr_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Terminal drive
  initial begin
    func_out = '0;
    fifth_general_input_out = 1'b0;
    table_addr_out = 4'h0;
  end
  // Levels change just after an edge, so the synchroniser never sees a race
  task set(input int i, input logic v);
    @(posedge sys_clk_in);
    func_out[i] <= v;
  endtask : set
  // Clear is held a fixed span; the real minimum would make the run far too long
  task clear_hold(input int n);
    set(F_DCLR, 1'b1);
    repeat (n) @(posedge sys_clk_in);
    func_out[F_DCLR] <= 1'b0;
  endtask : clear_hold
  // Proportional control is dropped before any brake request
  task brake_prep();
    set(F_PROP, 1'b0);
  endtask : brake_prep
endmodule : ssif_host_model

// ---- bench/tb.sv ----
// Testbench for the sequence input decoder
module tb;
  import ssif_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, cmd_pos = 32'h00001234, fb_pos = 32'h00000ABC, q;
  logic pready, pslverr, run_act = 0, pulse_op = 0, manual_op = 0, e, fifth;
  logic [SSIF_NF-1:0] func;
  logic [3:0] taddr;
  logic [15:0] aspd = 16'h0321, spd;
  logic [1:0] mode;
  logic pause, decel, ten, trev, load, inh;
  logic [31:0] load_val;
  int err_count = 0, checks_done = 0;
  logic prop, canc, pop, istop;
  int canc_n = 0, stop_n = 0;
  logic [1:0] mexp [3][2] = '{'{2'h0, 2'h1}, '{2'h0, 2'h2}, '{2'h1, 2'h2}};
  // ==========================================================
  // Clock and instances
  initial begin
    forever #2 clk = ~clk;
  end
  ssif_host_model host_u (.sys_clk_in(clk), .func_out(func), .fifth_general_input_out(fifth),
    .table_addr_out(taddr));
  ssif_seq_inputs dut_u (.sys_clk_in(clk), .resetn_in(rstn), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .func_in(func),
    .fifth_general_input_in(fifth), .table_addr_in(taddr), .cmd_pos_in(cmd_pos),
    .fb_pos_in(fb_pos), .analog_speed_in(aspd), .run_active_in(run_act),
    .pulse_op_in(pulse_op), .manual_op_in(manual_op), .ctl_mode_out(mode),
    .prop_ctrl_out(prop), .pause_out(pause), .decel_cfg_out(decel), .cancel_out(canc),
    .pulse_op_en_out(pop), .torque_en_out(ten), .torque_rev_out(trev), .int_stop_out(istop),
    .speed_ref_out(spd), .cmd_load_out(load), .cmd_load_val_out(load_val),
    .rotation_inhibit_out(inh));
  // Cancel and travel stop stand one cycle, so they are counted at every edge
  always @(posedge clk) begin
    if (canc === 1'b1) canc_n <= canc_n + 1;
    if (istop === 1'b1) stop_n <= stop_n + 1;
  end
  // ==========================================================
  // Tasks
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1;
    // Only the watchdog ends a wait that never sees ready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0; pen <= 0;
  endtask : apb
  task chk(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  // Outputs trail the pins by three or four edges; six leaves margin
  task settle();
    repeat (6) @(posedge clk);
  endtask : settle
  task print_verdict();
    $display("checks=%0d errors=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  // ==========================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    print_verdict();
  end
  // ==========================================================
  // Tests
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1;
    apb(0, A_OVW, 0); chk(q, OVW_RST);
    apb(0, A_MAXSPD, 0); chk(q, 32'h0000FFFF);
    apb(0, 8'h18, 0); chk(e, 1);
    apb(1, A_STATUS, 32'hFF); chk(e, 1);
    // Unmapped pause stays inactive
    run_act <= 1;
    host_u.set(F_PAUSE, 1); settle(); chk(pause, 0);
    apb(1, A_MAP, 32'h003FFFFF); settle(); chk(pause, 0);
    host_u.set(F_PAUSE, 0); settle();
    host_u.set(F_PAUSE, 1); settle(); chk({pause, decel}, 2'h3);
    host_u.set(F_PAUSE, 0); settle(); chk(pause, 0);
    manual_op <= 1;
    host_u.set(F_PAUSE, 1); settle(); chk(pause, 0);
    host_u.set(F_PAUSE, 0); manual_op <= 0;
    // Mode switching in the three dual modes
    for (int m = 0; m < 3; m++) begin
      apb(1, A_CFG, m + 3);
      for (int s = 0; s < 2; s++) begin
        host_u.set(F_MSW, s[0]); settle(); chk(mode, mexp[m][s]);
      end
    end
    apb(1, A_CFG, CM_SPD); settle(); chk(mode, 2'h1);
    // Speed codes
    for (int k = 1; k < 8; k++) apb(1, A_SPD_BASE + 8'(4 * (k - 1)), k * 100);
    for (int k = 0; k < 8; k++) begin
      host_u.set(F_X1, k[0]); host_u.set(F_X1 + 1, k[1]); host_u.set(F_X1 + 2, k[2]);
      settle(); chk(spd, k == 0 ? aspd : 16'(k * 100));
    end
    // Override on stored speed 7 (700): 10 percent, then capped at 150 and max
    host_u.set(F_OVEN, 1); host_u.set(F_OV1, 1); settle(); chk(spd, 16'd70);
    for (int b = 1; b < 4; b++) host_u.set(F_OV1 + b, 1);
    settle(); chk(spd, 16'd1050);
    apb(1, A_MAXSPD, 900); settle(); chk(spd, 16'd900);
    // Extension torque control
    apb(1, A_CFG, CM_EXT); host_u.set(F_TRQC, 1); settle(); chk(ten, 0);
    host_u.set(F_REV, 1); settle(); chk({mode, ten, trev}, 4'hB);
    host_u.set(F_REV, 0);
    // Deviation clear in level form
    apb(1, A_CFG, 32'h10);
    host_u.clear_hold(4);
    chk({inh, load}, 2'h3); chk(load_val, fb_pos);
    settle(); chk(inh, 0);
    // Edge form: load is a single pulse while the inhibit follows the level
    apb(1, A_CFG, 32'h00); host_u.clear_hold(4);
    chk({inh, load}, 2'h3); @(posedge clk); chk({inh, load}, 2'h2);
    // Teach into entry 5 in positioning mode
    apb(1, A_CFG, CM_POSN); host_u.table_addr_out <= 4'h5;
    host_u.set(F_TEACH, 1); settle(); apb(0, A_TAB_BASE + 8'h14, 0); chk(q, cmd_pos);
    apb(1, A_TAB_BASE, 1); chk(e, 1);
    // Interrupt run from the fifth input: speed held, override kept, stop after travel
    apb(1, A_TRAVEL, 32'h10); host_u.set(F_OVEN, 0); host_u.set(F_IEN, 1); settle();
    chk(spd, 16'd700);
    @(posedge clk); host_u.fifth_general_input_out <= 1; settle();
    apb(0, A_STATUS, 0); chk(q[4], 1);
    host_u.set(F_X1 + 1, 0); host_u.set(F_X1 + 2, 0); settle(); chk(spd, 16'd700);
    host_u.set(F_OVEN, 1); settle(); chk(spd, 16'd900);
    fb_pos <= 32'h00000ACB; settle(); chk(stop_n, 0);
    fb_pos <= 32'h00000ACC; settle(); chk(stop_n, 1);
    apb(0, A_STATUS, 0); chk(q[4], 0);
    // Cancel pulses once in a run, and is ignored in extension pulse operation
    host_u.set(F_CANCEL, 1); settle(); chk(canc_n, 1);
    host_u.set(F_CANCEL, 0);
    apb(1, A_CFG, CM_EXT); host_u.set(F_POSC, 1); host_u.set(F_RAT1, 1); settle();
    chk({mode, pop}, 3'h1); chk(spd, 16'd100);
    host_u.set(F_CANCEL, 1); settle(); chk(canc_n, 1);
    host_u.set(F_PROP, 1); settle(); chk(prop, 1);
    host_u.brake_prep(); settle(); chk(prop, 0);
    print_verdict();
  end
endmodule : tb
